// >>> verilog/idm_dma_engine.sv
`timescale 1ns/1ps
module idm_dma_engine import idm_pkg::*; #(
   parameter int BUF_DEPTH = IDM_BUF_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Per-channel command and status
   input wire logic [1:0] ch_start,
   input wire logic [1:0] ch_to_mem,
   input wire logic [1:0][31:0] ch_table_addr,
   input wire logic [1:0] ch_drv_done,
   output logic [1:0] ch_active,
   output logic [1:0] ch_finished,
   // Drive read data into the prefetch buffers
   input wire logic [1:0] drv_rd_valid,
   input wire logic [1:0][31:0] drv_rd_data,
   output logic [1:0] drv_rd_ready,
   // Drive write data out of the posted-write buffers
   output logic [1:0] drv_wr_valid,
   output logic [1:0][31:0] drv_wr_data,
   input wire logic [1:0] drv_wr_ready,
   // Bus master side
   output logic bus_req,
   input wire logic bus_gnt,
   output logic mem_valid,
   output logic mem_write,
   output logic mem_last,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);

   // ****************************************************************
   // Sizes and checks
   // ****************************************************************
   localparam int PW = $clog2(BUF_DEPTH);
   localparam int CW = $clog2(BUF_DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(BUF_DEPTH);
   localparam logic [CW-1:0] HALF = CW'(BUF_DEPTH / 2);
   localparam logic [CW-1:0] ONE = CW'(1);

   // Depth must be a power of two of at least four for pointer wrap
   if (BUF_DEPTH < 4 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
      $error("BUF_DEPTH must be a power of two, at least four");
   end

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      idm_state_e st;                   // Sequencer state
      logic own;                        // Channel that owns the engine
      logic [1:0] start_q;              // Last sampled start level
      logic [1:0] act;                  // Channel transfer active
      logic [1:0] done;                 // Channel table finished
      logic [1:0] dir;                  // 1 = drive to memory
      logic [1:0][31:0] tptr;           // Next descriptor address
      logic [31:0] addr;                // Current memory pointer
      logic [15:0] cnt;                 // Remaining byte count
      logic end_of_table_flag;                        // End flag of loaded descriptor
      logic need_desc;                  // Descriptor must be fetched
      logic [CW-1:0] beats;             // Beats left in the burst
      logic [1:0][BUF_DEPTH-1:0][31:0] pf_mem;
      logic [1:0][BUF_DEPTH-1:0][31:0] pw_mem;
      logic [1:0][PW-1:0] pf_wr;
      logic [1:0][PW-1:0] pf_rd;
      logic [1:0][PW-1:0] pw_wr;
      logic [1:0][PW-1:0] pw_rd;
      logic [1:0][CW-1:0] pf_cnt;
      logic [1:0][CW-1:0] pw_cnt;
      logic bus_req;                    // Registered port images
      logic mem_valid;
      logic mem_write;
      logic mem_last;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic [1:0] pf_rdy;
      logic [1:0] pw_vld;
      logic [1:0][31:0] pw_data;
   } idm_dma_s;

   idm_dma_s q;                         // Current state
   idm_dma_s d;                         // Next state

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Burst length: buffer room or data, cut to remaining doublewords
   function automatic logic [CW-1:0] burst_len(input logic [CW-1:0] avail,
                                                input logic [15:0] cnt);
      burst_len = (16'(avail) > {2'b00, cnt[15:2]}) ? CW'(cnt[15:2]) : avail;
   endfunction

   // Room or data offered to the next burst of the owning channel
   function automatic logic [CW-1:0] offer(input idm_dma_s s);
      if (s.dir[s.own]) begin
         // Full writes four, half writes two, a drive finish flushes
         if (s.pf_cnt[s.own] >= FULL) begin
            offer = FULL;
         end else if (s.pf_cnt[s.own] >= HALF) begin
            offer = HALF;
         end else if (ch_drv_done[s.own]) begin
            offer = s.pf_cnt[s.own];
         end else begin
            offer = '0;
         end
      end else begin
         // Empty reads four, half reads two, otherwise nothing
         if (s.pw_cnt[s.own] == '0) begin
            offer = FULL;
         end else if (s.pw_cnt[s.own] == HALF) begin
            offer = HALF;
         end else begin
            offer = '0;
         end
      end
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [CW-1:0] len;
      len = '0;
      d = q;
      d.start_q = ch_start;
      // Channel command handling, each channel on its own
      for (int c = 0; c < IDM_CH_NUM; c++) begin
         if (ch_start[c] && !q.start_q[c]) begin
            d.act[c] = 1'b1;
            d.done[c] = 1'b0;
            d.dir[c] = ch_to_mem[c];
            d.tptr[c] = ch_table_addr[c];
         end
         if (!ch_start[c]) begin
            // Stop clears the channel and empties its buffers
            d.act[c] = 1'b0;
            d.pf_cnt[c] = '0;
            d.pf_wr[c] = '0;
            d.pf_rd[c] = '0;
            d.pw_cnt[c] = '0;
            d.pw_wr[c] = '0;
            d.pw_rd[c] = '0;
         end else begin
            // Prefetch from drive while room remains
            if (drv_rd_valid[c] && q.pf_rdy[c]) begin
               d.pf_mem[c][d.pf_wr[c]] = drv_rd_data[c];
               d.pf_wr[c] = d.pf_wr[c] + 1'b1;
               d.pf_cnt[c] = d.pf_cnt[c] + ONE;
            end
            // Drain posted data to the drive at any time
            if (q.pw_vld[c] && drv_wr_ready[c]) begin
               d.pw_rd[c] = d.pw_rd[c] + 1'b1;
               d.pw_cnt[c] = d.pw_cnt[c] - ONE;
            end
         end
      end
      // Engine sequencer
      case (q.st)
         IDM_IDLE: begin
            // First channel wins when both wait
            if (d.act[0] && !d.done[0]) begin
               d.own = 1'b0;
               d.need_desc = 1'b1;
               d.st = IDM_WAIT;
            end else if (d.act[1] && !d.done[1]) begin
               d.own = 1'b1;
               d.need_desc = 1'b1;
               d.st = IDM_WAIT;
            end
         end
         IDM_WAIT: begin
            if (!d.act[q.own]) begin
               // Channel stopped, engine is free again
               d.st = IDM_IDLE;
            end else if (!q.need_desc && q.cnt == '0 && q.end_of_table_flag) begin
               // Table finished, channel reports done, engine free again
               d.done[q.own] = 1'b1;
               d.act[q.own] = 1'b0;
               d.st = IDM_IDLE;
            end else if (!q.need_desc && q.cnt == '0) begin
               // Next descriptor while drive side keeps moving
               d.need_desc = 1'b1;
            end else if (q.need_desc || burst_len(offer(d), q.cnt) != '0) begin
               d.st = IDM_ARB;
            end
         end
         IDM_ARB: begin
            if (bus_gnt) begin
               if (q.need_desc) begin
                  d.st = IDM_DESC0;
               end else begin
                  len = burst_len(offer(d), q.cnt);
                  d.beats = len;
                  d.st = (len != '0) ? IDM_BURST : IDM_WAIT;
               end
            end
         end
         IDM_DESC0: begin
            if (mem_ack) begin
               // Base address, bit 0 forced low
               d.addr = {mem_rdata[31:1], 1'b0};
               d.st = IDM_DESC1;
            end
         end
         IDM_DESC1: begin
            if (mem_ack) begin
               // Byte count and end flag
               d.cnt = {mem_rdata[IDM_CNT_MSB:1], 1'b0};
               d.end_of_table_flag = mem_rdata[IDM_EOT_BIT];
               d.tptr[q.own] = q.tptr[q.own] + IDM_DESC_BYTES;
               d.need_desc = 1'b0;
               // Keep the bus only if a burst is ready now
               len = burst_len(offer(d), d.cnt);
               d.beats = len;
               d.st = (len != '0) ? IDM_BURST : IDM_WAIT;
            end
         end
         IDM_BURST: begin
            if (mem_ack) begin
               if (q.dir[q.own]) begin
                  // Prefetched doubleword accepted by memory
                  if (d.pf_cnt[q.own] != '0) begin
                     d.pf_rd[q.own] = d.pf_rd[q.own] + 1'b1;
                     d.pf_cnt[q.own] = d.pf_cnt[q.own] - ONE;
                  end
               end else if (d.pw_cnt[q.own] != FULL) begin
                  // Read doubleword posted for the drive
                  d.pw_mem[q.own][d.pw_wr[q.own]] = mem_rdata;
                  d.pw_wr[q.own] = d.pw_wr[q.own] + 1'b1;
                  d.pw_cnt[q.own] = d.pw_cnt[q.own] + ONE;
               end
               // Whole doublewords only
               d.addr = q.addr + IDM_DW_BYTES;
               d.cnt = (q.cnt > 16'h0004) ? q.cnt - 16'h0004 : 16'h0000;
               d.beats = q.beats - ONE;
               // Bus released after the last beat
               if (q.beats == ONE) begin
                  d.st = IDM_WAIT;
               end
            end
         end
         default: begin
            d.st = IDM_IDLE;
         end
      endcase
      // Registered port images taken from the next state
      d.bus_req = (d.st != IDM_IDLE) && (d.st != IDM_WAIT);
      d.mem_valid = (d.st == IDM_DESC0) || (d.st == IDM_DESC1) || (d.st == IDM_BURST);
      d.mem_write = (d.st == IDM_BURST) && d.dir[d.own];
      d.mem_last = (d.st == IDM_DESC1) || ((d.st == IDM_BURST) && (d.beats == ONE));
      if (d.st == IDM_DESC0) begin
         d.mem_addr = {d.tptr[d.own][31:2], 2'b00};
      end else if (d.st == IDM_DESC1) begin
         d.mem_addr = {d.tptr[d.own][31:2], 2'b00} + IDM_DESC_W1_OFS;
      end else begin
         d.mem_addr = {d.addr[31:2], 2'b00};
      end
      d.mem_wdata = d.pf_mem[d.own][d.pf_rd[d.own]];
      for (int c = 0; c < IDM_CH_NUM; c++) begin
         d.pf_rdy[c] = d.act[c] && d.dir[c] && (d.pf_cnt[c] != FULL);
         d.pw_vld[c] = (d.pw_cnt[c] != '0);
         d.pw_data[c] = d.pw_mem[c][d.pw_rd[c]];
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= {$bits(idm_dma_s){IDM_RST_VAL}};
      end else begin
         q <= d;
      end
   end

   // Ports straight from the state flip-flops
   assign ch_active = q.act;
   assign ch_finished = q.done;
   assign drv_rd_ready = q.pf_rdy;
   assign drv_wr_valid = q.pw_vld;
   assign drv_wr_data = q.pw_data;
   assign bus_req = q.bus_req;
   assign mem_valid = q.mem_valid;
   assign mem_write = q.mem_write;
   assign mem_last = q.mem_last;
   assign mem_addr = q.mem_addr;
   assign mem_wdata = q.mem_wdata;

   // ****************************************************************
   // Checks
   // ****************************************************************
   owner_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st != IDM_IDLE) ##1 (q.st != IDM_IDLE) |-> q.own == $past(q.own))
      else $error("owner changed during a transfer");
   first_pick_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st == IDM_IDLE) && ch_start[0] && !q.start_q[0]
      |=> (q.own == 1'b0) && (q.st == IDM_WAIT))
      else $error("first channel not picked first");
   desc_pair_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st == IDM_DESC0) && mem_ack |=> (q.st == IDM_DESC1) && mem_last
      && (mem_addr == $past(mem_addr) + IDM_DESC_W1_OFS))
      else $error("descriptor words out of order");
   aligned_beat_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      mem_valid |-> mem_addr[1:0] == 2'b00)
      else $error("unaligned memory beat");
   pf_full_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.pf_cnt[0] == FULL) && ch_start[0] && !((q.st == IDM_BURST) && mem_ack && !q.own)
      |-> !drv_rd_ready[0] ##1 (q.pf_cnt[0] == FULL))
      else $error("prefetch accepted while full");
   wr_burst_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st != IDM_BURST) ##1 (q.st == IDM_BURST) && mem_write
      |-> (q.beats <= q.pf_cnt[q.own]) && (q.beats != '0))
      else $error("write burst larger than prefetched data");
   rd_burst_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st != IDM_BURST) ##1 (q.st == IDM_BURST) && !mem_write
      |-> (16'(q.beats) + 16'(q.pw_cnt[q.own]) <= 16'(FULL)))
      else $error("read burst overflows posted buffer");
   bus_free_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st == IDM_BURST) && mem_ack && (q.beats == ONE) |=> !bus_req ##1 !mem_valid)
      else $error("bus held after last beat");
   table_end_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.st == IDM_WAIT) && q.act[q.own] && !q.need_desc && (q.cnt == '0) && q.end_of_table_flag
      |=> ch_finished[$past(q.own)] && !bus_req && (q.st == IDM_IDLE))
      else $error("table end not reported");
   drain_now_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (q.pw_cnt[1] != '0) |-> drv_wr_valid[1])
      else $error("posted data not offered to drive");
endmodule // idm_dma_engine

// >>> verilog/idm_pkg.sv
// ****************************************************************
// Shared constants of the bus-master DMA engine
// ****************************************************************
package idm_pkg;
   // Number of drive channels served by the engine
   localparam int IDM_CH_NUM = 2;
   // Doubleword buffer depth per channel, half mark is depth / 2
   localparam int IDM_BUF_DEPTH = 4;
   // Bytes in one bus data beat
   localparam logic [31:0] IDM_DW_BYTES = 32'h0000_0004;
   // Bytes in one descriptor entry and offset of its second word
   localparam logic [31:0] IDM_DESC_BYTES = 32'h0000_0008;
   localparam logic [31:0] IDM_DESC_W1_OFS = 32'h0000_0004;
   // Descriptor field positions
   localparam int IDM_EOT_BIT = 31;
   localparam int IDM_CNT_MSB = 15;
   // Value of every state flip-flop after reset
   localparam logic IDM_RST_VAL = 1'b0;

   // Engine sequencer states
   typedef enum logic [2:0] {
      IDM_IDLE = 3'h0,
      IDM_WAIT = 3'h1,
      IDM_ARB = 3'h2,
      IDM_DESC0 = 3'h3,
      IDM_DESC1 = 3'h4,
      IDM_BURST = 3'h5
   } idm_state_e;
endpackage

// >>> bench/idm_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus arbiter and memory target seen by the engine
// ****************************************************************
module idm_mem_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Test controls: another master owns the bus, slow target
   input wire logic other_busy,
   input wire logic slow_ack,
   // Arbitration
   input wire logic bus_req,
   output logic bus_gnt,
   // Memory beats
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   // Word store, preloaded by the bench
   logic [31:0] mem [0:127];
   // Beat acknowledge and slow-mode pacing
   logic ack_q;
   logic tick_q;

   assign mem_ack = ack_q;
   // Table words and data served as stored; inverted outside an ack
   assign mem_rdata = ack_q ? mem[mem_addr[8:2]] : ~mem[mem_addr[8:2]];

   // Grant follows request unless another master holds the bus
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_gnt <= 1'b0;
         ack_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         bus_gnt <= bus_req & ~other_busy;
         tick_q <= ~tick_q;
         ack_q <= mem_valid & ~ack_q & bus_gnt & (~slow_ack | tick_q);
         // Store a write beat on its acknowledge
         if (mem_valid & mem_write & ack_q) begin
            mem[mem_addr[8:2]] <= mem_wdata;
         end
      end
   end
endmodule // idm_mem_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// Engine testbench
// ****************************************************************
module testbench import idm_pkg::*; ;
   // Design inputs
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] ch_start = 2'h0;
   logic [1:0] ch_to_mem = 2'h0;
   logic [1:0] ch_drv_done = 2'h0;
   logic [1:0] drv_rd_valid = 2'h0;
   logic [1:0] drv_wr_ready = 2'h0;
   logic [1:0][31:0] ch_table_addr = '0;
   logic [1:0][31:0] drv_rd_data = '0;
   logic other_busy = 1'b0;
   logic slow_ack = 1'b0;
   // Design outputs
   logic [1:0] ch_active, ch_finished, drv_rd_ready, drv_wr_valid;
   logic [1:0][31:0] drv_wr_data;
   logic bus_req, bus_gnt, mem_valid, mem_write, mem_last, mem_ack;
   logic [31:0] mem_addr, mem_wdata, mem_rdata;
   // Drive models and score
   int rd_idx [2];
   int rd_len [2];
   int wr_n [2];
   logic [31:0] wr_got [2][0:15];
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   always #25 clk_sys = ~clk_sys;

   idm_dma_engine u_idm_dma_engine (.clk_sys(clk_sys), .rst_b(rst_b), .ch_start(ch_start),
      .ch_to_mem(ch_to_mem), .ch_table_addr(ch_table_addr), .ch_drv_done(ch_drv_done),
      .ch_active(ch_active), .ch_finished(ch_finished), .drv_rd_valid(drv_rd_valid),
      .drv_rd_data(drv_rd_data), .drv_rd_ready(drv_rd_ready), .drv_wr_valid(drv_wr_valid),
      .drv_wr_data(drv_wr_data), .drv_wr_ready(drv_wr_ready), .bus_req(bus_req),
      .bus_gnt(bus_gnt), .mem_valid(mem_valid), .mem_write(mem_write), .mem_last(mem_last),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   idm_mem_model u_idm_mem_model (.clk_sys(clk_sys), .rst_b(rst_b), .other_busy(other_busy),
      .slow_ack(slow_ack), .bus_req(bus_req), .bus_gnt(bus_gnt), .mem_valid(mem_valid),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));

   // ****************************************************************
   // Drive side models
   // ****************************************************************
   function automatic logic [31:0] pat(input int c, input int i);
      return 32'hA500_0000 + 32'(c) * 32'h0001_0000 + 32'(i);
   endfunction

   // Count taken prefetch words, capture posted-write words; a stopped channel starts over
   always @(posedge clk_sys) begin
      for (int c = 0; c < 2; c++) begin
         if (ch_start[c] !== 1'b1) begin
            rd_idx[c] <= 0;
            wr_n[c] <= 0;
         end else begin
            if (drv_rd_valid[c] && drv_rd_ready[c] === 1'b1) begin
               rd_idx[c] <= rd_idx[c] + 1;
            end
            if (drv_wr_valid[c] === 1'b1 && drv_wr_ready[c]) begin
               wr_got[c][wr_n[c] % 16] <= drv_wr_data[c];
               wr_n[c] <= wr_n[c] + 1;
            end
         end
      end
   end

   // Offer words off the sampling edge; write side stalls every other cycle
   always @(negedge clk_sys) begin
      cyc <= cyc + 1;
      for (int c = 0; c < 2; c++) begin
         drv_rd_valid[c] <= (rd_idx[c] < rd_len[c]);
         drv_rd_data[c] <= (rd_idx[c] < rd_len[c]) ? pat(c, rd_idx[c]) : ~pat(c, cyc);
         drv_wr_ready[c] <= cyc[0];
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Bounded wait for a channel to end its table, or its drive to take n words
   task automatic wait_for(input int c, input int n);
      int k;
      for (k = 0; k < 3000; k++) begin
         @(negedge clk_sys);
         if (n == 0 && ch_finished[c] === 1'b1) return;
         if (n > 0 && wr_n[c] >= n) return;
      end
      bad_count++;
      $display("ERROR wait timed out on channel %0d", c);
      wrap_up();
   endtask

   // Aligned base and count, region inside one 64k page
   task automatic put_desc(input int at, input logic [31:0] base, input logic [15:0] cnt,
      input logic end_of_table_flag);
      u_idm_mem_model.mem[at / 4] = base;
      u_idm_mem_model.mem[at / 4 + 1] = {end_of_table_flag, 15'h0000, cnt};
   endtask

   task automatic start(input int c, input logic to_mem, input logic [31:0] tbl);
      ch_table_addr[c] = tbl;
      ch_to_mem[c] = to_mem;
      ch_start[c] = 1'b1;
   endtask

   task automatic stop_all();
      ch_start = 2'h0;
      repeat (3) @(negedge clk_sys);
      rd_len = '{0, 0};
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Bus held by another master: prefetch stops at four, then one burst of four
   task automatic t_busy_fill();
      put_desc(32'h000, 32'h0000_0100, 16'h0010, 1'b1);
      other_busy = 1'b1;
      rd_len[0] = 6;
      start(0, 1'b1, 32'h000);
      repeat (20) @(negedge clk_sys);
      check("prefetch words", 32'd4, 32'(rd_idx[0]));
      check("prefetch ready", 32'd0, 32'(drv_rd_ready[0]));
      check("request held", 32'd1, 32'(bus_req));
      check("channel active", 32'd1, 32'(ch_active[0]));
      other_busy = 1'b0;
      wait_for(0, 0);
      for (int i = 0; i < 4; i++) begin
         check("burst word", pat(0, i), u_idm_mem_model.mem[64 + i]);
      end
      repeat (3) @(negedge clk_sys);
      check("bus released", 32'd0, 32'(bus_req));
      stop_all();
   endtask

   // Chained descriptors, slow target: two beats each, next table entry fetched
   task automatic t_chain();
      put_desc(32'h010, 32'h0000_0140, 16'h0008, 1'b0);
      put_desc(32'h018, 32'h0000_0160, 16'h0008, 1'b1);
      slow_ack = 1'b1;
      rd_len[0] = 4;
      start(0, 1'b1, 32'h010);
      wait_for(0, 0);
      for (int i = 0; i < 2; i++) begin
         check("first region", pat(0, i), u_idm_mem_model.mem[80 + i]);
         check("second region", pat(0, i + 2), u_idm_mem_model.mem[88 + i]);
      end
      slow_ack = 1'b0;
      stop_all();
   endtask

   // Memory to drive, six words: burst of four, refill of two, drive drains
   task automatic t_to_drive();
      for (int i = 0; i < 6; i++) u_idm_mem_model.mem[96 + i] = 32'hC0DE_0000 + 32'(i);
      put_desc(32'h020, 32'h0000_0180, 16'h0018, 1'b1);
      start(1, 1'b0, 32'h020);
      wait_for(1, 0);
      repeat (3) @(negedge clk_sys);
      check("bus off after fill", 32'd0, 32'(bus_req));
      wait_for(1, 6);
      for (int i = 0; i < 6; i++) begin
         check("drive word", 32'hC0DE_0000 + 32'(i), wr_got[1][i]);
      end
      stop_all();
   endtask

   // Both channels start together: first channel owns the engine to its end
   task automatic t_both();
      put_desc(32'h028, 32'h0000_01A0, 16'h0008, 1'b1);
      put_desc(32'h030, 32'h0000_01C0, 16'h0008, 1'b1);
      u_idm_mem_model.mem[112] = 32'h5A5A_0001;
      u_idm_mem_model.mem[113] = 32'h5A5A_0002;
      rd_len[0] = 2;
      start(0, 1'b1, 32'h028);
      start(1, 1'b0, 32'h030);
      wait_for(0, 0);
      check("second waits", 32'd0, 32'(ch_finished[1]));
      wait_for(1, 2);
      check("ch0 region", pat(0, 0), u_idm_mem_model.mem[104]);
      check("ch0 region", pat(0, 1), u_idm_mem_model.mem[105]);
      check("ch1 drive", 32'h5A5A_0001, wr_got[1][0]);
      check("ch1 drive", 32'h5A5A_0002, wr_got[1][1]);
      stop_all();
   endtask

   // Drive finished after one word: the partial prefetch goes out as a single beat
   task automatic t_flush();
      put_desc(32'h038, 32'h0000_01E0, 16'h0004, 1'b1);
      rd_len[0] = 1;
      ch_drv_done[0] = 1'b1;
      start(0, 1'b1, 32'h038);
      wait_for(0, 0);
      check("flushed word", pat(0, 0), u_idm_mem_model.mem[120]);
      check("channel idle", 32'd0, 32'(ch_active[0]));
      ch_drv_done = 2'h0;
      stop_all();
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rd_len = '{0, 0};
      for (int i = 0; i < 128; i++) u_idm_mem_model.mem[i] = 32'h0000_0000;
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      t_busy_fill();
      t_chain();
      t_to_drive();
      t_both();
      t_flush();
      wrap_up();
   end
endmodule // testbench
